// File: hdl/clk_gate_cfg.svh
// Purpose: Offsets, field positions, reset values and counts of the clock gating controller
// Assumes: Register index times four gives the Wishbone byte address
// Notes:   Definitions only
`ifndef CLK_GATE_CFG_SVH
`define CLK_GATE_CFG_SVH

// ****************************************
// Register indexes
// ****************************************
`define CG_IDX_IRQ_EN_CLR   6'h01
`define CG_IDX_IRQ_EN_SET   6'h02
`define CG_IDX_IRQ_FLAG     6'h03
`define CG_IDX_CPU_DIV      6'h04
`define CG_IDX_AHB_GATE     6'h10
`define CG_IDX_APB_A_GATE   6'h14
`define CG_IDX_APB_B_GATE   6'h18
`define CG_IDX_APB_C_GATE   6'h1C

// ****************************************
// Field positions
// ****************************************
`define CG_BIT_CLOCK_READY  0
`define CG_BIT_AHB_APB_A    0
`define CG_BIT_APB_A_SELF   2

// ****************************************
// Reset values
// ****************************************
`define CG_RST_IRQ_EN       1'h0
`define CG_RST_IRQ_FLAG     1'h1
`define CG_RST_CPU_DIV      8'h01
`define CG_RST_AHB_GATE     32'h000005FF
`define CG_RST_APB_A_GATE   32'h00000FFF
`define CG_RST_APB_B_GATE   32'h00000017
`define CG_RST_APB_C_GATE   32'h00000000

// ****************************************
// Counts
// ****************************************
`define CG_DIV_WIDTH        8
`define CG_CNT_WIDTH        7

`endif

// File: hdl/clk_gate_pkg.sv
// Purpose: Types shared by the clock gating controller
// Assumes: Included configuration header
// Notes:   Legal divider check is used by the main controller only, terminal count by the prescaler
`include "clk_gate_cfg.svh"
`default_nettype none

package clk_gate_pkg;

  typedef logic [`CG_DIV_WIDTH-1:0] div_t;
  typedef logic [`CG_CNT_WIDTH-1:0] cnt_t;
  typedef logic [31:0]              gate_t;

  // One-hot divider value check
  function automatic logic is_legal_div(input div_t d);
    is_legal_div = (d != 8'h00) && ((d & (d - 8'h01)) == 8'h00);
  endfunction

  // Division factor minus one as a terminal count
  function automatic cnt_t div_limit(input div_t d);
    div_limit = cnt_t'(d - 8'h01);
  endfunction

endpackage

`default_nettype wire

// File: hdl/presc_if.sv
// Purpose: Carrier between register logic and the CPU prescaler
// Assumes: One clock
// Notes:   ctrl drives the divider, presc answers with tick and ready
`default_nettype none

interface presc_if;
  clk_gate_pkg::div_t div;
  logic               load;
  logic               freeze;
  logic               tick;
  logic               ready;

  modport ctrl  (output div, output load, output freeze, input tick, input ready);
  modport presc (input div, input load, input freeze, output tick, output ready);
endinterface

`default_nettype wire

// File: hdl/cpu_prescaler.sv
// Purpose: Divides the main root clock into a CPU clock enable pulse
// Assumes: Divider value already checked one-hot by the caller
// Notes:   A new factor takes effect on the next period boundary
`default_nettype none

module cpu_prescaler (
  input  wire logic clk_i,
  input  wire logic rst_i,
  presc_if.presc    pif
);

  clk_gate_pkg::cnt_t cnt_r;
  clk_gate_pkg::cnt_t lim_r;
  clk_gate_pkg::cnt_t pend_lim_r;
  logic               pend_r;
  logic               ready_r;
  logic               at_end;

  assign at_end    = (cnt_r == lim_r);
  assign pif.tick  = at_end & ~pif.freeze;
  assign pif.ready = ready_r;

  // ****************************************
  // Counter and switch-over
  // ****************************************
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cnt_r      <= 7'h00;
      lim_r      <= 7'h00;
      pend_lim_r <= 7'h00;
      pend_r     <= 1'b0;
      ready_r    <= 1'b1;
    end else if (pif.load) begin
      pend_lim_r <= clk_gate_pkg::div_limit(pif.div);
      pend_r     <= 1'b1;
      ready_r    <= 1'b0;
    end else if (!pif.freeze) begin
      if (at_end) begin
        cnt_r <= 7'h00;
        if (pend_r) begin
          lim_r   <= pend_lim_r;
          pend_r  <= 1'b0;
          ready_r <= 1'b1;
        end
      end else begin
        cnt_r <= cnt_r + 7'h01;
      end
    end
  end

endmodule

`default_nettype wire

// File: hdl/main_clock_gating_irq.sv
// Purpose: Main clock controller with peripheral clock gates and clock ready interrupt
// Assumes: Classic Wishbone slave, one word per register, single clock
// Notes:   Gated clocks leave as clock enable pulses on the CPU tick
//
// Our own choice: register access over Wishbone.
`include "clk_gate_cfg.svh"
`default_nettype none

module main_clock_gating_irq #(
  parameter logic [31:0] AHB_RESET   = `CG_RST_AHB_GATE,
  parameter logic [31:0] APB_A_RESET = `CG_RST_APB_A_GATE,
  parameter logic [31:0] APB_B_RESET = `CG_RST_APB_B_GATE,
  parameter logic [31:0] APB_C_RESET = `CG_RST_APB_C_GATE
) (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        cyc_i,
  input  wire logic        stb_i,
  input  wire logic        we_i,
  input  wire logic [7:0]  adr_i,
  input  wire logic [3:0]  sel_i,
  input  wire logic [31:0] dat_i,
  output logic [31:0]      dat_o,
  output logic             ack_o,
  input  wire logic        sleep_idle_i,
  input  wire logic        sleep_standby_i,
  input  wire logic        clk_request_i,
  output logic             cpu_clk_en_o,
  output logic [31:0]      ahb_clk_en_o,
  output logic [31:0]      apb_a_clk_en_o,
  output logic [31:0]      apb_b_clk_en_o,
  output logic [31:0]      apb_c_clk_en_o,
  output logic             irq_o,
  output logic             wake_o,
  output logic             access_violation_o
);

  // ****************************************
  // Declarations
  // ****************************************
  presc_if pif ();

  logic                 ack_r;
  logic [31:0]          dat_r;
  logic                 irq_en_r;
  logic                 irq_flag_r;
  clk_gate_pkg::div_t   cpu_div_r;
  clk_gate_pkg::gate_t  ahb_gate_r;
  clk_gate_pkg::gate_t  apb_a_gate_r;
  clk_gate_pkg::gate_t  apb_b_gate_r;
  clk_gate_pkg::gate_t  apb_c_gate_r;
  logic                 ready_d_r;
  logic                 viol_r;

  logic                 req;
  logic                 wr;
  logic [5:0]           idx;
  logic                 mapped;
  logic                 wr_clr;
  logic                 wr_set;
  logic                 wr_flag;
  logic                 wr_div;
  logic                 wr_gate;
  logic                 locked;
  logic                 div_legal;
  logic                 div_load;
  logic                 ready_rise;
  logic                 frozen;
  logic [31:0]          wmask;
  logic [31:0]          rd_mux;
  logic [31:0]          tick_vec;

  // ****************************************
  // Elaboration checks
  // ****************************************
  if (!AHB_RESET[`CG_BIT_AHB_APB_A] || !APB_A_RESET[`CG_BIT_APB_A_SELF]) begin : g_reset_lock
    $error("Reset masks would lock the register bus");
  end
  if (`CG_CNT_WIDTH < `CG_DIV_WIDTH - 1) begin : g_cnt_width
    $error("Prescaler counter too narrow for the largest divider");
  end

  // ****************************************
  // Bus decode
  // ****************************************
  assign req     = cyc_i & stb_i;
  assign wr      = req & we_i & ack_r;
  assign idx     = adr_i[7:2];
  assign wmask   = {{8{sel_i[3]}}, {8{sel_i[2]}}, {8{sel_i[1]}}, {8{sel_i[0]}}};
  assign mapped  = (adr_i[1:0] == 2'h0) &&
                   ((idx == `CG_IDX_IRQ_EN_CLR) || (idx == `CG_IDX_IRQ_EN_SET) ||
                    (idx == `CG_IDX_IRQ_FLAG)   || (idx == `CG_IDX_CPU_DIV)    ||
                    (idx == `CG_IDX_AHB_GATE)   || (idx == `CG_IDX_APB_A_GATE) ||
                    (idx == `CG_IDX_APB_B_GATE) || (idx == `CG_IDX_APB_C_GATE));
  assign wr_clr  = wr & sel_i[0] & (idx == `CG_IDX_IRQ_EN_CLR) & ~locked;
  assign wr_set  = wr & sel_i[0] & (idx == `CG_IDX_IRQ_EN_SET) & ~locked;
  assign wr_flag = wr & sel_i[0] & (idx == `CG_IDX_IRQ_FLAG) & ~locked;
  assign wr_div  = wr & sel_i[0] & (idx == `CG_IDX_CPU_DIV) & ~locked;
  assign wr_gate = wr & ~locked & pif.ready;

  // Own clock or its bridge gated off: registers stay frozen until reset
  assign locked  = ~apb_a_gate_r[`CG_BIT_APB_A_SELF] | ~ahb_gate_r[`CG_BIT_AHB_APB_A];

  // ****************************************
  // Divider and clock ready
  // ****************************************
  assign div_legal  = clk_gate_pkg::is_legal_div(dat_i[7:0]);
  assign div_load   = wr_div & div_legal & pif.ready;
  assign ready_rise = pif.ready & ~ready_d_r;
  assign frozen     = sleep_standby_i & ~clk_request_i;
  assign pif.div    = dat_i[7:0];
  assign pif.load   = div_load;
  assign pif.freeze = frozen;

  cpu_prescaler u_presc (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .pif   (pif)
  );

  // ****************************************
  // Clock gates
  // ****************************************
  assign tick_vec       = {32{pif.tick}};
  assign cpu_clk_en_o   = pif.tick;
  assign ahb_clk_en_o   = ahb_gate_r & tick_vec;
  assign apb_a_clk_en_o = apb_a_gate_r & tick_vec;
  assign apb_b_clk_en_o = apb_b_gate_r & tick_vec;
  assign apb_c_clk_en_o = apb_c_gate_r & tick_vec;

  // ****************************************
  // Interrupt and wake
  // ****************************************
  assign irq_o              = irq_flag_r & irq_en_r;
  assign wake_o             = irq_o & (sleep_idle_i | sleep_standby_i);
  assign access_violation_o = viol_r;

  // ****************************************
  // Read data
  // ****************************************
  assign rd_mux = (idx == `CG_IDX_IRQ_EN_CLR) ? {31'h0, irq_en_r} :
                  (idx == `CG_IDX_IRQ_EN_SET) ? {31'h0, irq_en_r} :
                  (idx == `CG_IDX_IRQ_FLAG)   ? {31'h0, irq_flag_r} :
                  (idx == `CG_IDX_CPU_DIV)    ? {24'h0, cpu_div_r} :
                  (idx == `CG_IDX_AHB_GATE)   ? ahb_gate_r :
                  (idx == `CG_IDX_APB_A_GATE) ? apb_a_gate_r :
                  (idx == `CG_IDX_APB_B_GATE) ? apb_b_gate_r :
                  (idx == `CG_IDX_APB_C_GATE) ? apb_c_gate_r : 32'h00000000;

  assign ack_o = ack_r;
  assign dat_o = dat_r;

  // ****************************************
  // Bus handshake
  // ****************************************
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_r <= 1'b0;
      dat_r <= 32'h00000000;
    end else begin
      ack_r <= req & ~ack_r;
      dat_r <= (mapped && !we_i) ? rd_mux : 32'h00000000;
    end
  end

  // ****************************************
  // Interrupt state
  // ****************************************
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_en_r   <= `CG_RST_IRQ_EN;
      irq_flag_r <= `CG_RST_IRQ_FLAG;
      ready_d_r  <= 1'b1;
    end else begin
      ready_d_r <= pif.ready;
      if (wr_set && dat_i[`CG_BIT_CLOCK_READY]) begin
        irq_en_r <= 1'b1;
      end else if (wr_clr && dat_i[`CG_BIT_CLOCK_READY]) begin
        irq_en_r <= 1'b0;
      end
      if (ready_rise) begin
        irq_flag_r <= 1'b1;
      end else if (div_load) begin
        irq_flag_r <= 1'b0;
      end else if (wr_flag && dat_i[`CG_BIT_CLOCK_READY]) begin
        irq_flag_r <= 1'b0;
      end
    end
  end

  // ****************************************
  // Divider register and violation
  // ****************************************
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cpu_div_r <= `CG_RST_CPU_DIV;
      viol_r    <= 1'b0;
    end else begin
      if (div_load) begin
        cpu_div_r <= dat_i[7:0];
      end
      viol_r <= (wr_div & (~div_legal | ~pif.ready)) |
                (wr & ~locked & ~pif.ready &
                 ((idx == `CG_IDX_AHB_GATE) || (idx == `CG_IDX_APB_A_GATE) ||
                  (idx == `CG_IDX_APB_B_GATE) || (idx == `CG_IDX_APB_C_GATE)));
    end
  end

  // ****************************************
  // Mask registers
  // ****************************************
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ahb_gate_r   <= AHB_RESET;
      apb_a_gate_r <= APB_A_RESET;
      apb_b_gate_r <= APB_B_RESET;
      apb_c_gate_r <= APB_C_RESET;
    end else if (wr_gate) begin
      if (idx == `CG_IDX_AHB_GATE) begin
        ahb_gate_r <= (ahb_gate_r & ~wmask) | (dat_i & wmask);
      end
      if (idx == `CG_IDX_APB_A_GATE) begin
        apb_a_gate_r <= (apb_a_gate_r & ~wmask) | (dat_i & wmask);
      end
      if (idx == `CG_IDX_APB_B_GATE) begin
        apb_b_gate_r <= (apb_b_gate_r & ~wmask) | (dat_i & wmask);
      end
      if (idx == `CG_IDX_APB_C_GATE) begin
        apb_c_gate_r <= (apb_c_gate_r & ~wmask) | (dat_i & wmask);
      end
    end
  end

endmodule

`default_nettype wire

// File: dv/cg_props.sv
// Purpose: Port checker for the clock gating controller
// Assumes: Divide by one after reset
// Notes:   Bound from the bench
`default_nettype none

module cg_props #(
  parameter logic [31:0] AHB_RESET   = 32'h0,
  parameter logic [31:0] APB_A_RESET = 32'h0,
  parameter logic [31:0] APB_B_RESET = 32'h0,
  parameter logic [31:0] APB_C_RESET = 32'h0
) (
  input wire logic        clk_i,
  input wire logic        rst_i,
  input wire logic        we_i,
  input wire logic [7:0]  adr_i,
  input wire logic [3:0]  sel_i,
  input wire logic [31:0] dat_i,
  input wire logic        ack_o,
  input wire logic        sleep_idle_i,
  input wire logic        sleep_standby_i,
  input wire logic        clk_request_i,
  input wire logic        cpu_clk_en_o,
  input wire logic [31:0] ahb_clk_en_o,
  input wire logic [31:0] apb_a_clk_en_o,
  input wire logic [31:0] apb_b_clk_en_o,
  input wire logic [31:0] apb_c_clk_en_o,
  input wire logic        irq_o,
  input wire logic        wake_o,
  input wire logic        access_violation_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // ********
  // Checks
  // ********
  gate_tick_a: assert property (
    (|{ahb_clk_en_o, apb_a_clk_en_o, apb_b_clk_en_o, apb_c_clk_en_o}) |-> cpu_clk_en_o)
    else $error("gate pulse without cpu tick");
  reset_gate_a: assert property (
    $past(rst_i) && cpu_clk_en_o |-> ahb_clk_en_o == AHB_RESET && apb_a_clk_en_o == APB_A_RESET
      && apb_b_clk_en_o == APB_B_RESET && apb_c_clk_en_o == APB_C_RESET)
    else $error("gates differ from reset masks");
  wake_level_a: assert property (
    wake_o == (irq_o && (sleep_idle_i || sleep_standby_i)))
    else $error("wake does not follow request in sleep");
  irq_hold_a: assert property (
    $fell(irq_o) |-> $past(ack_o && we_i))
    else $error("request dropped without a write");
  idle_run_a: assert property (
    sleep_idle_i && !sleep_standby_i |-> ##[0:256] cpu_clk_en_o)
    else $error("cpu tick stopped in idle");
  standby_freeze_a: assert property (
    (sleep_standby_i && !clk_request_i) [*2] |-> !cpu_clk_en_o)
    else $error("cpu tick in standby without request");
  violation_pulse_a: assert property (
    access_violation_o |-> $past(ack_o && we_i) ##1 !access_violation_o)
    else $error("violation without write or too long");
  bad_div_a: assert property (
    ack_o && we_i && adr_i == 8'h10 && sel_i[0] && !$onehot(dat_i[7:0]) |=> access_violation_o)
    else $error("illegal divider not reported");
  cover property (access_violation_o);
  cover property (irq_o && wake_o);
  cover property (sleep_standby_i && clk_request_i && cpu_clk_en_o);
endmodule

`default_nettype wire

// File: dv/main_clock_gating_irq_tb.sv
// Purpose: Self checking bench of the clock gating controller
// Assumes: Classic Wishbone master, ack one cycle after request
// Notes:   Each scenario is a task
`include "clk_gate_cfg.svh"
`default_nettype none

module main_clock_gating_irq_tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [7:0] A_CLR = {`CG_IDX_IRQ_EN_CLR, 2'b00};
  localparam logic [7:0] A_SET = {`CG_IDX_IRQ_EN_SET, 2'b00};
  localparam logic [7:0] A_FLG = {`CG_IDX_IRQ_FLAG, 2'b00};
  localparam logic [7:0] A_DIV = {`CG_IDX_CPU_DIV, 2'b00};
  localparam logic [7:0] A_AHB = {`CG_IDX_AHB_GATE, 2'b00};
  localparam logic [7:0] A_APA = {`CG_IDX_APB_A_GATE, 2'b00};
  localparam logic [7:0] A_APB = {`CG_IDX_APB_B_GATE, 2'b00};
  localparam logic [7:0] A_APC = {`CG_IDX_APB_C_GATE, 2'b00};
  logic        clk_i = 0, rst_i = 1, cyc_i = 0, stb_i = 0, we_i = 0;
  logic        sleep_idle_i = 0, sleep_standby_i = 0, clk_request_i = 0;
  logic [7:0]  adr_i = 8'h00;
  logic [3:0]  sel_i = 4'h0;
  logic [31:0] dat_i = 32'h0, dat_o, rd;
  logic [31:0] ahb_clk_en_o, apb_a_clk_en_o, apb_b_clk_en_o, apb_c_clk_en_o;
  logic        ack_o, cpu_clk_en_o, irq_o, wake_o, access_violation_o;
  int          failures = 0, checks = 0, cycles = 0;

  main_clock_gating_irq i_main_clock_gating_irq (
    .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i),
    .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o), .sleep_idle_i(sleep_idle_i),
    .sleep_standby_i(sleep_standby_i), .clk_request_i(clk_request_i), .cpu_clk_en_o(cpu_clk_en_o),
    .ahb_clk_en_o(ahb_clk_en_o), .apb_a_clk_en_o(apb_a_clk_en_o), .apb_b_clk_en_o(apb_b_clk_en_o),
    .apb_c_clk_en_o(apb_c_clk_en_o), .irq_o(irq_o), .wake_o(wake_o),
    .access_violation_o(access_violation_o));

  always #20 clk_i = ~clk_i;
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 20000) begin
      failures++;
      summarize();
    end
  end

  // ********
  // Tasks
  // ********
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      failures++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
    @(posedge clk_i);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i <= w;
    adr_i <= a;
    dat_i <= d;
    sel_i <= s;
    repeat (20) begin
      @(posedge clk_i);
      if (ack_o === 1'b1) break;
    end
    check(32'(ack_o), 32'h1);
    rd = dat_o;
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    we_i <= 1'b0;
  endtask

  task automatic tick_sync;
    repeat (300) begin
      @(posedge clk_i);
      if (cpu_clk_en_o === 1'b1) break;
    end
  endtask

  task automatic wait_ready;
    repeat (100) begin
      wb(1'b0, A_FLG, 32'h0, 4'hF);
      if (rd === 32'h1) break;
    end
  endtask

  task automatic do_reset;
    @(posedge clk_i);
    rst_i <= 1'b1;
    repeat (6) @(posedge clk_i);
    rst_i <= 1'b0;
  endtask

  task automatic summarize;
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  // ********
  // Scenarios
  // ********
  task automatic t_reset;
    logic [7:0]  adr [9];
    logic [31:0] exp [9];
    adr = '{A_CLR, A_SET, A_FLG, A_DIV, A_AHB, A_APA, A_APB, A_APC, 8'h24};
    exp = '{32'(`CG_RST_IRQ_EN), 32'(`CG_RST_IRQ_EN), 32'(`CG_RST_IRQ_FLAG), 32'(`CG_RST_CPU_DIV),
            `CG_RST_AHB_GATE, `CG_RST_APB_A_GATE, `CG_RST_APB_B_GATE, `CG_RST_APB_C_GATE, 32'h0};
    for (int k = 0; k < 9; k++) begin
      wb(1'b0, adr[k], 32'h0, 4'hF);
      check(rd, exp[k]);
    end
    check(ahb_clk_en_o, `CG_RST_AHB_GATE);
    $display("reset test done");
  endtask

  task automatic t_sleep;
    @(posedge clk_i);
    sleep_standby_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    check(32'(cpu_clk_en_o), 32'h0);
    clk_request_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    check(32'(cpu_clk_en_o), 32'h1);
    sleep_standby_i <= 1'b0;
    clk_request_i <= 1'b0;
    sleep_idle_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    check(32'(cpu_clk_en_o), 32'h1);
    sleep_idle_i <= 1'b0;
    $display("sleep test done");
  endtask

  task automatic t_irq;
    wb(1'b1, A_SET, 32'h1, 4'h1);
    sleep_idle_i <= 1'b1;
    @(posedge clk_i);
    check(32'(irq_o), 32'h1);
    check(32'(wake_o), 32'h1);
    sleep_idle_i <= 1'b0;
    wb(1'b0, A_CLR, 32'h0, 4'hF);
    check(rd, 32'h1);
    wb(1'b1, A_FLG, 32'h0, 4'h1);
    @(posedge clk_i);
    check(32'(irq_o), 32'h1);
    wb(1'b1, A_CLR, 32'h1, 4'h1);
    @(posedge clk_i);
    check(32'(irq_o), 32'h0);
    wb(1'b0, A_SET, 32'h0, 4'hF);
    check(rd, 32'h0);
    wb(1'b1, A_SET, 32'h1, 4'h1);
    wb(1'b1, A_FLG, 32'h1, 4'h1);
    @(posedge clk_i);
    check(32'(irq_o), 32'h0);
    $display("irq test done");
  endtask

  task automatic t_div;
    int n;
    wb(1'b1, A_DIV, 32'h80, 4'h1);
    wait_ready();
    check(rd, 32'h1);
    tick_sync();
    wb(1'b1, A_DIV, 32'h02, 4'h1);
    wb(1'b0, A_FLG, 32'h0, 4'hF);
    check(rd, 32'h0);
    wb(1'b1, A_AHB, 32'h0, 4'hF);
    @(posedge clk_i);
    check(32'(access_violation_o), 32'h1);
    wait_ready();
    check(rd, 32'h1);
    wb(1'b0, A_AHB, 32'h0, 4'hF);
    check(rd, `CG_RST_AHB_GATE);
    tick_sync();
    n = 1;
    @(posedge clk_i);
    while (cpu_clk_en_o !== 1'b1 && n < 300) begin
      n++;
      @(posedge clk_i);
    end
    check(32'(n), 32'h2);
    wb(1'b1, A_DIV, 32'h03, 4'h1);
    @(posedge clk_i);
    check(32'(access_violation_o), 32'h1);
    wb(1'b0, A_DIV, 32'h0, 4'hF);
    check(rd, 32'h2);
    wb(1'b1, A_DIV, 32'h01, 4'h1);
    wait_ready();
    check(rd, 32'h1);
    $display("divider test done");
  endtask

  task automatic t_gate;
    wb(1'b1, A_APC, 32'h1, 4'h1);
    @(posedge clk_i);
    check(apb_c_clk_en_o, 32'h1);
    wb(1'b1, A_APB, 32'hFFFFFFFF, 4'h2);
    @(posedge clk_i);
    check(apb_b_clk_en_o, 32'h0000FF17);
    check(ahb_clk_en_o, `CG_RST_AHB_GATE);
    wb(1'b1, A_APC, 32'h0, 4'hF);
    @(posedge clk_i);
    check(apb_c_clk_en_o, 32'h0);
    $display("gate test done");
  endtask

  task automatic t_lock;
    wb(1'b1, A_AHB, `CG_RST_AHB_GATE & ~32'h1, 4'hF); // Flash clock kept
    wb(1'b1, A_APC, 32'hF, 4'hF);
    wb(1'b0, A_APC, 32'h0, 4'hF);
    check(rd, 32'h0);
    do_reset();
    wb(1'b0, A_AHB, 32'h0, 4'hF);
    check(rd, `CG_RST_AHB_GATE);
    wb(1'b1, A_APA, `CG_RST_APB_A_GATE & ~32'h4, 4'hF);
    wb(1'b1, A_APB, 32'h0, 4'hF);
    wb(1'b0, A_APB, 32'h0, 4'hF);
    check(rd, `CG_RST_APB_B_GATE);
    $display("lock test done");
  endtask

  initial begin
    do_reset();
    t_reset();
    t_sleep();
    t_irq();
    t_div();
    t_gate();
    t_lock();
    summarize();
  end
endmodule

bind main_clock_gating_irq cg_props #(.AHB_RESET(AHB_RESET), .APB_A_RESET(APB_A_RESET),
  .APB_B_RESET(APB_B_RESET), .APB_C_RESET(APB_C_RESET)) i_cg_props (
  .clk_i(clk_i), .rst_i(rst_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i),
  .ack_o(ack_o), .sleep_idle_i(sleep_idle_i), .sleep_standby_i(sleep_standby_i),
  .clk_request_i(clk_request_i), .cpu_clk_en_o(cpu_clk_en_o), .ahb_clk_en_o(ahb_clk_en_o),
  .apb_a_clk_en_o(apb_a_clk_en_o), .apb_b_clk_en_o(apb_b_clk_en_o), .apb_c_clk_en_o(apb_c_clk_en_o),
  .irq_o(irq_o), .wake_o(wake_o), .access_violation_o(access_violation_o));

`default_nettype wire
